//--- core/tcrb_pkg.sv
// Constants, register map and carrier types of the top control register bank.
package tcrb_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] CMP_CTRL_ADDR  = 8'h05;
  localparam logic [7:0] BUS_CNFG_ADDR  = 8'h40;
  localparam logic [7:0] SRST_ADDR      = 8'h50;
  localparam logic [7:0] SHIP_CTRL_ADDR = 8'h51;

  // ==========================================================================
  // Values after reset and the reset key
  localparam logic [7:0] CMP_CTRL_RST  = 8'h01;
  localparam logic [7:0] BUS_CNFG_RST  = 8'h20;
  localparam logic [7:0] SRST_RST      = 8'h00;
  localparam logic [7:0] SHIP_CTRL_RST = 8'h00;
  localparam logic [7:0] SRST_KEY      = 8'hA5;
  // Bit 7 of the comparator control register is not implemented.
  localparam logic [7:0] CMP_CTRL_MASK = 8'h7F;
  localparam logic [7:0] RD_NONE       = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int DUTY_EN_BIT  = 3;
  localparam int OV_DIS_BIT   = 2;
  localparam int OV_DEB_BIT   = 1;
  localparam int DIE_DIS_BIT  = 0;
  localparam int PAIR_BIT     = 4;
  localparam int HS_EXT_BIT   = 0;
  localparam int SHIP_SEL_BIT = 0;

  // ==========================================================================
  // Timing
  localparam real CLK_PERIOD_NS    = 25.0;
  localparam real DUTY_PERIOD_MS   = 3.0;
  localparam real DUTY_ON_MS       = 0.1;
  localparam real OV_DEB_MS        = 5.0;
  localparam real SHIP_LONG_MS     = 10.0;
  localparam real SHIP_SHORT_MS    = 0.1;
  localparam int  DUTY_PERIOD_CYC  = int'(DUTY_PERIOD_MS * 1.0E6 / CLK_PERIOD_NS);
  localparam int  DUTY_ON_CYC      = int'(DUTY_ON_MS * 1.0E6 / CLK_PERIOD_NS);
  localparam int  OV_DEB_CYC       = int'(OV_DEB_MS * 1.0E6 / CLK_PERIOD_NS);
  localparam int  SHIP_LONG_CYC    = int'(SHIP_LONG_MS * 1.0E6 / CLK_PERIOD_NS);
  localparam int  SHIP_SHORT_CYC   = int'(SHIP_SHORT_MS * 1.0E6 / CLK_PERIOD_NS);

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } tcrb_bus_state_t;

  typedef struct packed {
    logic die;
    logic thermistor;
    logic ovlo;
    logic uvlo;
  } tcrb_cmp_en_t;

  localparam tcrb_cmp_en_t CMP_EN_RST = '{die: 1'b0, thermistor: 1'b1, ovlo: 1'b1, uvlo: 1'b1};

endpackage

//--- core/tcrb_duty_cycler.sv
// Period timer that opens a short on-window in every comparator duty cycle.
`timescale 1ns/1ps
`default_nettype none
module tcrb_duty_cycler #(
  parameter int PERIOD_CYCLES = tcrb_pkg::DUTY_PERIOD_CYC,
  parameter int ON_CYCLES     = tcrb_pkg::DUTY_ON_CYC
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Control and phase
  input  wire logic run_in,
  output var  logic phase_on_out
);
  import tcrb_pkg::*;

  localparam int CW = $clog2(PERIOD_CYCLES + 1);

  logic [CW-1:0] cnt_reg;

  // ==========================================================================
  // Period counter
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !run_in)
      cnt_reg <= '0;
    else if (cnt_reg == CW'(PERIOD_CYCLES - 1))
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + 1'b1;
  end

  // The phase reads high whenever cycling is stopped.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      phase_on_out <= 1'b1;
    else
      phase_on_out <= !run_in || (cnt_reg < CW'(ON_CYCLES));
  end

endmodule // tcrb_duty_cycler
`default_nettype wire

//--- core/tcrb_top.sv
// Top control register bank: comparator control, soft reset, ship timer, bus options.
`timescale 1ns/1ps
`default_nettype none
module tcrb_top #(
  parameter int DUTY_PERIOD_CYC = tcrb_pkg::DUTY_PERIOD_CYC,
  parameter int OV_DEB_CYC      = tcrb_pkg::OV_DEB_CYC,
  parameter int SHIP_LONG_CYC   = tcrb_pkg::SHIP_LONG_CYC
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  // Byte stream from the serial bus front end
  input  wire logic                  bus_start_in,
  input  wire logic                  bus_stop_in,
  input  wire logic                  bus_hs_code_in,
  input  wire logic                  bus_wr_valid_in,
  input  wire logic [7:0]            bus_wr_byte_in,
  input  wire logic                  bus_rd_req_in,
  output var  logic [7:0]            bus_rd_data_out,
  output var  logic                  bus_rd_valid_out,
  output var  logic                  hs_mode_out,
  // Analog and pin side
  input  wire logic                  charger_input_valid_in,
  input  wire logic                  thermistor_cmp_disable_in,
  input  wire logic                  sys_overvolt_raw_in,
  input  wire logic                  ship_button_in,
  output var  tcrb_pkg::tcrb_cmp_en_t cmp_en_out,
  output var  logic                  sys_overvolt_fault_out,
  output var  logic                  ship_exit_out
);
  import tcrb_pkg::*;

  localparam int DW = $clog2(OV_DEB_CYC + 1);
  localparam int SW = $clog2(SHIP_LONG_CYC + 1);

  tcrb_bus_state_t state_reg;
  logic [7:0]      ptr_reg;
  logic [7:0]      cmp_ctrl_reg;
  logic [7:0]      bus_cnfg_reg;
  logic [7:0]      srst_reg;
  logic [7:0]      ship_ctrl_reg;
  logic [7:0]      rd_mux;
  logic            reg_wr;
  logic            key_hit;
  logic            phase_on;
  logic            duty_en;
  logic            pair_mode;
  logic            hs_ext;
  logic [DW-1:0]   deb_cnt_reg;
  logic [SW-1:0]   ship_cnt_reg;
  logic [SW-1:0]   ship_target;
  logic            ship_done_reg;

  assign reg_wr    = bus_wr_valid_in && (state_reg == ST_DATA);
  assign key_hit   = reg_wr && (ptr_reg == SRST_ADDR) && (bus_wr_byte_in == SRST_KEY);
  assign duty_en   = cmp_ctrl_reg[DUTY_EN_BIT];
  assign pair_mode = bus_cnfg_reg[PAIR_BIT];
  assign hs_ext    = bus_cnfg_reg[HS_EXT_BIT];

  // ==========================================================================
  // Transfer sequencer
  // START opens a transfer whose first written byte is the register address.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || bus_stop_in)
      state_reg <= ST_IDLE;
    else if (bus_start_in)
      state_reg <= ST_ADDR;
    else if (bus_wr_valid_in)
    begin
      unique case (state_reg)
        ST_IDLE: state_reg <= ST_IDLE;
        ST_ADDR: state_reg <= ST_DATA;
        ST_DATA: state_reg <= pair_mode ? ST_ADDR : ST_DATA;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Writes take precedence over a read request in the same cycle.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      ptr_reg <= 8'h00;
    else if (bus_wr_valid_in && state_reg == ST_ADDR && !bus_start_in)
      ptr_reg <= bus_wr_byte_in;
    else if (reg_wr && !bus_start_in && !bus_stop_in)
      ptr_reg <= pair_mode ? ptr_reg : ptr_reg + 8'h01;
    else if (bus_rd_req_in)
      ptr_reg <= ptr_reg + 8'h01;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || key_hit)
      cmp_ctrl_reg <= CMP_CTRL_RST;
    else if (reg_wr && ptr_reg == CMP_CTRL_ADDR)
      cmp_ctrl_reg <= bus_wr_byte_in & CMP_CTRL_MASK;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || key_hit)
      bus_cnfg_reg <= BUS_CNFG_RST;
    else if (reg_wr && ptr_reg == BUS_CNFG_ADDR)
      bus_cnfg_reg <= bus_wr_byte_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || key_hit)
      ship_ctrl_reg <= SHIP_CTRL_RST;
    else if (reg_wr && ptr_reg == SHIP_CTRL_ADDR)
      ship_ctrl_reg <= bus_wr_byte_in;
  end

  // The key clears itself; any other value is simply held.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || key_hit)
      srst_reg <= SRST_RST;
    else if (reg_wr && ptr_reg == SRST_ADDR)
      srst_reg <= bus_wr_byte_in;
  end

  always_comb
  begin
    unique case (ptr_reg)
      CMP_CTRL_ADDR:  rd_mux = cmp_ctrl_reg;
      BUS_CNFG_ADDR:  rd_mux = bus_cnfg_reg;
      SRST_ADDR:      rd_mux = srst_reg;
      SHIP_CTRL_ADDR: rd_mux = ship_ctrl_reg;
      default:        rd_mux = RD_NONE;
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      bus_rd_data_out  <= 8'h00;
      bus_rd_valid_out <= 1'b0;
    end
    else
    begin
      bus_rd_valid_out <= bus_rd_req_in && !reg_wr;
      if (bus_rd_req_in && !reg_wr)
        bus_rd_data_out <= rd_mux;
    end
  end

  // ==========================================================================
  // High-speed mode
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      hs_mode_out <= 1'b0;
    else if (hs_ext)
      hs_mode_out <= 1'b1;
    else if (bus_hs_code_in)
      hs_mode_out <= 1'b1;
    else if (bus_stop_in)
      hs_mode_out <= 1'b0;
  end

  // ==========================================================================
  // Comparator enables
  tcrb_duty_cycler #(
    .PERIOD_CYCLES (DUTY_PERIOD_CYC),
    .ON_CYCLES     (DUTY_ON_CYC)
  ) u_duty (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n_in),
    .run_in       (duty_en),
    .phase_on_out (phase_on)
  );

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
      cmp_en_out <= CMP_EN_RST;
    else
    begin
      cmp_en_out.uvlo  <= !duty_en || phase_on;
      cmp_en_out.ovlo  <= !cmp_ctrl_reg[OV_DIS_BIT] && (!duty_en || phase_on);
      cmp_en_out.thermistor <= !thermistor_cmp_disable_in && (!duty_en || phase_on);
      cmp_en_out.die   <= charger_input_valid_in || !cmp_ctrl_reg[DIE_DIS_BIT];
    end
  end

  // ==========================================================================
  // Overvoltage debounce
  // The count pauses while duty cycling has the comparator switched off.
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || cmp_ctrl_reg[OV_DIS_BIT] || (cmp_en_out.ovlo && !sys_overvolt_raw_in))
    begin
      deb_cnt_reg            <= '0;
      sys_overvolt_fault_out <= 1'b0;
    end
    else if (cmp_en_out.ovlo)
    begin
      if (!cmp_ctrl_reg[OV_DEB_BIT])
        sys_overvolt_fault_out <= 1'b1;
      else if (deb_cnt_reg == DW'(OV_DEB_CYC - 1))
        sys_overvolt_fault_out <= 1'b1;
      else
        deb_cnt_reg <= deb_cnt_reg + 1'b1;
    end
  end

  // ==========================================================================
  // Ship-mode exit timer
  assign ship_target = ship_ctrl_reg[SHIP_SEL_BIT] ? SW'(SHIP_SHORT_CYC) : SW'(SHIP_LONG_CYC);

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in || !ship_button_in)
    begin
      ship_cnt_reg  <= '0;
      ship_done_reg <= 1'b0;
      ship_exit_out <= 1'b0;
    end
    else if (ship_done_reg)
      ship_exit_out <= 1'b0;
    else if (ship_cnt_reg == ship_target - 1'b1)
    begin
      ship_done_reg <= 1'b1;
      ship_exit_out <= 1'b1;
    end
    else
      ship_cnt_reg <= ship_cnt_reg + 1'b1;
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  uvlo_always_on_a: assert property (!duty_en [*2] |=> cmp_en_out.uvlo)
    else $error("Undervoltage comparator off without duty cycling.");
  duty_off_phase_a: assert property (duty_en && !phase_on |=>
    !cmp_en_out.uvlo && !cmp_en_out.ovlo && !cmp_en_out.thermistor)
    else $error("Comparators powered in the off phase.");
  tcmp_on_phase_a: assert property (duty_en && phase_on && !thermistor_cmp_disable_in |=>
    cmp_en_out.thermistor)
    else $error("Thermistor comparator off in the on phase.");
  ovlo_follows_dis_a: assert property (!duty_en |=>
    cmp_en_out.ovlo == !$past(cmp_ctrl_reg[OV_DIS_BIT]))
    else $error("Overvoltage comparator does not follow its disable bit.");
  ovlo_no_deb_a: assert property (!cmp_ctrl_reg[OV_DEB_BIT] && !cmp_ctrl_reg[OV_DIS_BIT]
    && cmp_en_out.ovlo && sys_overvolt_raw_in |=> sys_overvolt_fault_out)
    else $error("Undebounced fault not raised at once.");
  ovlo_deb_time_a: assert property ($rose(sys_overvolt_fault_out)
    && $past(cmp_ctrl_reg[OV_DEB_BIT]) |-> $past(deb_cnt_reg) == DW'(OV_DEB_CYC - 1))
    else $error("Debounced fault raised early.");
  die_forced_on_a: assert property (charger_input_valid_in |=> cmp_en_out.die)
    else $error("Die thermal comparator off with valid charger input.");
  key_resets_a: assert property (key_hit |=> cmp_ctrl_reg == CMP_CTRL_RST
    && bus_cnfg_reg == BUS_CNFG_RST && ship_ctrl_reg == SHIP_CTRL_RST && srst_reg == SRST_RST)
    else $error("Reset key did not restore defaults.");
  nonkey_store_a: assert property (reg_wr && ptr_reg == SRST_ADDR && !key_hit |=>
    srst_reg == $past(bus_wr_byte_in) && $stable(cmp_ctrl_reg))
    else $error("Non-key reset write misbehaved.");
  ship_time_a: assert property ($rose(ship_exit_out) |->
    $past(ship_cnt_reg) == $past(ship_target) - 1'b1)
    else $error("Ship exit timer length wrong.");
  pair_addr_a: assert property (reg_wr && pair_mode && !bus_start_in && !bus_stop_in |=>
    state_reg == ST_ADDR && $stable(ptr_reg))
    else $error("Paired mode did not return to address phase.");
  seq_incr_a: assert property (reg_wr && !pair_mode && !bus_start_in && !bus_stop_in |=>
    state_reg == ST_DATA && ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("Sequential mode did not advance the address.");
  hs_std_exit_a: assert property (!hs_ext && bus_stop_in && !bus_hs_code_in |=>
    !hs_mode_out)
    else $error("High speed kept after STOP without extension.");
  hs_ext_keep_a: assert property (hs_ext |=> hs_mode_out [*2])
    else $error("High speed lost with extension on.");

  pair_burst_c: cover property (reg_wr && pair_mode ##[1:20] reg_wr);
  hs_code_c:    cover property (!hs_ext && bus_hs_code_in ##1 hs_mode_out);
  key_hit_c:    cover property (key_hit);
  deb_fault_c:  cover property ($rose(sys_overvolt_fault_out) && cmp_ctrl_reg[OV_DEB_BIT]);
  duty_off_c:   cover property (duty_en && $fell(phase_on));

endmodule // tcrb_top
`default_nettype wire

//--- bench/tcrb_host_model.sv
// Host-side model of the serial bus front end that feeds the register bank.
`timescale 1ns/1ps
`default_nettype none
module tcrb_host_model (
  // Clock
  input  wire logic       clk_in,
  // Byte stream towards the bank
  output var  logic       start_out,
  output var  logic       stop_out,
  output var  logic       hs_code_out,
  output var  logic       wr_valid_out,
  output var  logic [7:0] wr_byte_out,
  output var  logic       rd_req_out,
  // Read answer
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in
);
  initial
  begin
    {start_out, stop_out, hs_code_out, wr_valid_out, rd_req_out} = 5'h00;
    wr_byte_out = 8'h00;
  end

  // Selects 0 start, 1 stop, 2 high-speed code for a one-cycle pulse.
  task automatic pulse(input int sel);
    @(negedge clk_in);
    start_out   = (sel == 0);
    stop_out    = (sel == 1);
    hs_code_out = (sel == 2);
    @(negedge clk_in);
    {start_out, stop_out, hs_code_out} = 3'h0;
  endtask

  // A released byte line shows the inverse of its last value.
  task automatic send(input int n, input logic [7:0] b [4]);
    pulse(0);
    for (int i = 0; i < n; i++)
    begin
      @(negedge clk_in);
      wr_valid_out = 1'b1;
      wr_byte_out  = b[i];
    end
    @(negedge clk_in);
    wr_valid_out = 1'b0;
    wr_byte_out  = ~wr_byte_out;
    pulse(1);
  endtask

  task automatic read(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    pulse(0);
    @(negedge clk_in);
    wr_valid_out = 1'b1;
    wr_byte_out  = addr;
    @(negedge clk_in);
    wr_valid_out = 1'b0;
    wr_byte_out  = ~addr;
    rd_req_out   = 1'b1;
    @(negedge clk_in);
    rd_req_out = 1'b0;
    for (int i = 0; i < 4 && rd_valid_in !== 1'b1; i++)
      @(negedge clk_in);
    ok   = rd_valid_in;
    data = rd_data_in;
    pulse(1);
  endtask
endmodule // tcrb_host_model
`default_nettype wire

//--- bench/tb_top.sv
// Self-checking testbench of the top control register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tcrb_pkg::*;
  localparam int DUTY_P = 8000;
  localparam int DEB    = 20;
  localparam int SHIP_L = 5000;

  logic         clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  logic         start, stop, hs_code, wr_valid, rd_req, rd_valid, hs_mode;
  logic [7:0]   wr_byte, rd_data;
  logic         chg_ok = 1'b0, tcmp_dis = 1'b0, ov_raw = 1'b0, button = 1'b0;
  logic         fault, ship_exit;
  tcrb_cmp_en_t cmp_en;
  int           failures = 0, tests_run = 0, n;

  always #12.5 clk_in = ~clk_in;

  tcrb_top #(.DUTY_PERIOD_CYC(DUTY_P), .OV_DEB_CYC(DEB), .SHIP_LONG_CYC(SHIP_L)) dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .bus_start_in(start), .bus_stop_in(stop),
    .bus_hs_code_in(hs_code), .bus_wr_valid_in(wr_valid), .bus_wr_byte_in(wr_byte),
    .bus_rd_req_in(rd_req), .bus_rd_data_out(rd_data), .bus_rd_valid_out(rd_valid),
    .hs_mode_out(hs_mode), .charger_input_valid_in(chg_ok),
    .thermistor_cmp_disable_in(tcmp_dis), .sys_overvolt_raw_in(ov_raw),
    .ship_button_in(button), .cmp_en_out(cmp_en), .sys_overvolt_fault_out(fault),
    .ship_exit_out(ship_exit));

  tcrb_host_model host (
    .clk_in(clk_in), .start_out(start), .stop_out(stop), .hs_code_out(hs_code),
    .wr_valid_out(wr_valid), .wr_byte_out(wr_byte), .rd_req_out(rd_req),
    .rd_data_in(rd_data), .rd_valid_in(rd_valid));

  // ==========================================================================
  // Checking and bus helpers
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int t);
    tests_run++;
    if ((g >= e && g <= e + t) !== 1'b1)
    begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host.read(a, d, ok);
    chk("read valid", 1, {31'h0, ok}, 0);
    chk($sformatf("register %0h", a), {24'h0, e}, {24'h0, d}, 0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.send(2, '{a, d, 8'h00, 8'h00});
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(negedge clk_in);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_in);
    failures++;
    complete_run();
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    wait_cyc(12);
    rst_n_in = 1'b1;
    rd_chk(CMP_CTRL_ADDR, CMP_CTRL_RST);
    rd_chk(BUS_CNFG_ADDR, BUS_CNFG_RST);
    rd_chk(SRST_ADDR, 8'h00);
    rd_chk(SHIP_CTRL_ADDR, 8'h00);
    rd_chk(8'h33, RD_NONE);
    $display("test reset_values done");
    host.send(3, '{SRST_ADDR, 8'h12, 8'h01, 8'h00});
    rd_chk(SRST_ADDR, 8'h12);
    rd_chk(SHIP_CTRL_ADDR, 8'h01);
    wr(BUS_CNFG_ADDR, 8'h30);
    host.send(4, '{SHIP_CTRL_ADDR, 8'h03, CMP_CTRL_ADDR, 8'hFF});
    rd_chk(SHIP_CTRL_ADDR, 8'h03);
    rd_chk(CMP_CTRL_ADDR, 8'h7F);
    $display("test bursts done");
    wr(SRST_ADDR, SRST_KEY);
    rd_chk(CMP_CTRL_ADDR, CMP_CTRL_RST);
    rd_chk(BUS_CNFG_ADDR, BUS_CNFG_RST);
    rd_chk(SRST_ADDR, 8'h00);
    rd_chk(SHIP_CTRL_ADDR, SHIP_CTRL_RST);
    $display("test soft_reset done");
    wr(CMP_CTRL_ADDR, 8'h05);
    wait_cyc(3);
    chk("uvlo enable", 1, {31'h0, cmp_en.uvlo}, 0);
    chk("ovlo enable", 0, {31'h0, cmp_en.ovlo}, 0);
    chk("die enable", 0, {31'h0, cmp_en.die}, 0);
    chg_ok = 1'b1;
    wait_cyc(3);
    chk("die enable", 1, {31'h0, cmp_en.die}, 0);
    wr(CMP_CTRL_ADDR, 8'h00);
    wait_cyc(3);
    chk("ovlo enable", 1, {31'h0, cmp_en.ovlo}, 0);
    ov_raw = 1'b1;
    wait_cyc(3);
    chk("fault", 1, {31'h0, fault}, 0);
    ov_raw = 1'b0;
    wr(CMP_CTRL_ADDR, 8'h02);
    ov_raw = 1'b1;
    wait_cyc(DEB - 8);
    chk("fault", 0, {31'h0, fault}, 0);
    wait_cyc(12);
    chk("fault", 1, {31'h0, fault}, 0);
    ov_raw = 1'b0;
    $display("test comparators done");
    tcmp_dis = 1'b1;
    wr(CMP_CTRL_ADDR, 8'h08);
    for (n = 0; cmp_en.uvlo !== 1'b0 && n < 9000; n++)
      @(negedge clk_in);
    for (n = 0; cmp_en.uvlo === 1'b0 && n < 9000; n++)
      @(negedge clk_in);
    chk("off cycles", DUTY_P - DUTY_ON_CYC, n, 0);
    wait_cyc(2);
    chk("thermistor enable", 0, {31'h0, cmp_en.thermistor}, 0);
    chk("ovlo enable", 1, {31'h0, cmp_en.ovlo}, 0);
    for (n = 2; cmp_en.uvlo === 1'b1 && n < 9000; n++)
      @(negedge clk_in);
    chk("on cycles", DUTY_ON_CYC, n, 0);
    wr(CMP_CTRL_ADDR, 8'h01);
    tcmp_dis = 1'b0;
    $display("test duty_cycle done");
    for (int s = 0; s < 2; s++)
    begin
      wr(SHIP_CTRL_ADDR, (s == 0) ? 8'h01 : 8'h00);
      button = 1'b1;
      for (n = 0; ship_exit !== 1'b1 && n < 6000; n++)
        @(negedge clk_in);
      chk("ship timer", ((s == 0) ? SHIP_SHORT_CYC : SHIP_L) - 1, n, 3);
      button = 1'b0;
      wait_cyc(2);
    end
    $display("test ship_timer done");
    chk("hs mode", 0, {31'h0, hs_mode}, 0);
    host.pulse(2);
    wait_cyc(2);
    chk("hs mode", 1, {31'h0, hs_mode}, 0);
    host.pulse(1);
    wait_cyc(2);
    chk("hs mode", 0, {31'h0, hs_mode}, 0);
    wr(BUS_CNFG_ADDR, 8'h21);
    wait_cyc(2);
    chk("hs mode", 1, {31'h0, hs_mode}, 0);
    host.pulse(1);
    wait_cyc(2);
    chk("hs mode", 1, {31'h0, hs_mode}, 0);
    wr(BUS_CNFG_ADDR, 8'h20);
    wait_cyc(2);
    chk("hs mode", 0, {31'h0, hs_mode}, 0);
    $display("test high_speed done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
